// ---- rtl/rfdw_pkg.sv ----
// Purpose: Shared constants for frame descriptor write-back
// Assumes: Descriptor words are 32 bits, byte offsets below
// Notes: APB offsets are byte addresses of aligned words
// =====================================================
// Package
package rfdw_pkg;
  // Descriptor word byte offsets
  localparam logic [7:0] W0_OFF = 8'h00;
  localparam logic [7:0] W2_OFF = 8'h08;
  localparam logic [7:0] W3_OFF = 8'h0C;
  localparam logic [7:0] HDR_OFF = 8'h10;
  // Word 0 fields
  localparam int LIST_END_BIT = 31;
  localparam int SUSP_BIT = 30;
  localparam int LAYOUT_BIT = 19;
  localparam int C_BIT = 15;
  localparam int B_BIT = 14;
  localparam int OK_BIT = 13;
  localparam int ST_LEN = 12;
  localparam int ST_CRC = 11;
  localparam int ST_ALN = 10;
  localparam int ST_NRES = 9;
  localparam int ST_OVR = 8;
  localparam int ST_SHRT = 7;
  localparam int ST_NOCL = 6;
  localparam int ST_TRNC = 5;
  localparam int ST_NOMATCH = 1;
  localparam int ST_COLL = 0;
  // Word 3 fields
  localparam int EOF_BIT = 15;
  localparam int F_BIT = 14;
  localparam int SIZE_LSB = 16;
  localparam logic [31:0] NO_BD = 32'hFFFF_FFFF;
  localparam int HDR_BYTES = 16;
  localparam logic [2:0] MAX_ADDR_LEN = 3'h6;
  // APB register byte offsets
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STA_LO = 12'h004;
  localparam logic [11:0] A_STA_HI = 12'h008;
  localparam logic [11:0] A_STAT = 12'h00C;
  localparam logic [11:0] A_CNT = 12'h010;
  localparam int NCNT = 5;
  // Control: [0] save bad, [1] length check, [6:4] address length
  localparam int CT_SAVE = 0;
  localparam int CT_LCHK = 1;
  localparam int CT_ALEN = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0060;
  // Status register bits
  localparam int SR_BUSY = 0;
  localparam int SR_SUSP = 1;
  localparam int SR_END = 2;
  localparam int SR_LAST = 16;
  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE, S_OPEN, S_RECV, S_CALC, S_HDR, S_W3, S_W2, S_FIN
  } rfdw_state_t;
endpackage

// ---- rtl/rfdw_core.sv ----
// Purpose: Receive frame descriptor write-back engine
// Assumes: Fetch and framer logic on core_clk_i hold inputs stable
// Notes: Memory writes use a valid/ready word port
// How it works
// - End-of-list descriptor stops the list after its frame.
// - Suspend bit halts the receive unit once its frame finished.
// - Simplified layout writes all ones as buffer pointer.
// - Flexible layout writes the chained buffer pointer.
// - Active flag written 1 at setup, 0 at completion.
// - Done and active flags change in one word write.
// - Errored frames kept only when save-bad is enabled.
// - Errors counted even for discarded frames.
// - Length error reported only when length check enabled.
// - CRC error on byte-aligned frame sets bit 11.
// - CRC error on misaligned frame sets bit 10.
// - Out of buffer space sets bit 9.
// - Bus overrun sets bit 8.
// - Short frame bit 7, missing closing flag bit 6, 2-4 zero.
// - Truncation bit 5 only in simplified with save-bad.
// - Bit 1 clear when destination equals station address.
// - Late collision after destination sets bit 0.
// - Link field passed on as next descriptor location.
// - All-ones buffer pointer is never followed.
// - Length field stored most significant byte first.
// - Last, used, size, count fields behave as buffer ones.
// - Filled count is 14 bits of meaningful bytes.
// - Header fields packed back to back in memory.
// - Last-buffer flag written at end of reception.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/100ps
module rfdw_core
  import rfdw_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic core_clk_i, // 10 MHz clock
  input wire logic resetn_i, // Async reset, low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [11:0] paddr_i, // APB address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error
  output logic rx_ready_o, // May start a frame
  input wire logic rx_start_i, // Frame setup pulse
  input wire logic [31:0] fd_base_i, // Descriptor address
  input wire logic [15:0] fd_ctrl_i, // Descriptor upper half
  input wire logic [31:0] fd_link_i, // Descriptor link
  input wire logic [13:0] fd_size_i, // Descriptor size
  input wire logic [31:0] bd_ptr_i, // First buffer pointer
  input wire logic rx_byte_valid_i, // Header byte strobe
  input wire logic [7:0] rx_byte_i, // Header byte
  input wire logic rx_end_i, // End of frame pulse
  input wire logic [13:0] rx_count_i, // Bytes kept
  input wire logic err_len_i, // Length error
  input wire logic err_crc_i, // Frame check error
  input wire logic misalign_i, // Not byte aligned
  input wire logic no_res_i, // Out of buffers
  input wire logic overrun_i, // Bus overrun
  input wire logic too_short_i, // Short frame
  input wire logic no_close_i, // Closing flag missing
  input wire logic truncated_i, // Frame truncated
  input wire logic collision_i, // Late collision
  output logic mem_wvalid_o, // Memory write request
  output logic [31:0] mem_addr_o, // Memory write address
  output logic [31:0] mem_data_o, // Memory write data
  input wire logic mem_wready_i, // Memory write taken
  output logic frame_done_o, // Descriptor closed pulse
  output logic frame_drop_o, // Frame discarded pulse
  output logic [31:0] next_fd_o, // Next descriptor
  output logic bd_follow_o, // Buffer chain to walk
  output logic rx_suspended_o, // Receive unit halted
  output logic list_end_o // End of list reached
);

  // =====================================================
  // Registers and state
  rfdw_state_t state_r, state_nxt;
  logic [31:0] ctrl_r, sta_lo_r, sta_hi_r;
  logic susp_r, end_r;
  logic [15:0] fctl_r;
  logic [31:0] base_r, link_r, bd_r;
  logic [13:0] size_r, cnt_r;
  logic [7:0] hdr_r [HDR_BYTES];
  logic [3:0] hcnt_r;
  logic [2:0] alen_r;
  logic [8:0] ev_r;
  logic pend_r;
  logic [12:0] stat_r, last_r;
  logic ok_r;
  logic [1:0] widx_r, widx_nxt;
  logic [CNT_W-1:0] ecnt_r [NCNT];
  logic [31:0] wdata_nxt;
  logic [7:0] woff_nxt;
  logic nomatch;
  logic wr_go;

  wire logic save_bad = ctrl_r[CT_SAVE];
  wire logic layout_sel = fctl_r[LAYOUT_BIT-16];
  wire logic [3:0] hlen = {alen_r, 1'b0} + 4'h2;
  wire logic [1:0] hlast = 2'((hlen - 4'h1) >> 2);
  wire logic apb_wr = psel_i & penable_i & pwrite_i;

  // Decode a register address, used by the error path only
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= A_CNT + 12'h010);
  endfunction

  // =====================================================
  // APB slave: zero wait states, read data latched at setup
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped(paddr_i);

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      unique case (paddr_i)
        A_CTRL: prdata_o <= ctrl_r;
        A_STA_LO: prdata_o <= sta_lo_r;
        A_STA_HI: prdata_o <= sta_hi_r;
        A_STAT: prdata_o <= {3'h0, last_r, 13'h0000, end_r, susp_r,
                             (state_r != S_IDLE)};
        A_CNT: prdata_o <= 32'(ecnt_r[0]);
        A_CNT + 12'h004: prdata_o <= 32'(ecnt_r[1]);
        A_CNT + 12'h008: prdata_o <= 32'(ecnt_r[2]);
        A_CNT + 12'h00C: prdata_o <= 32'(ecnt_r[3]);
        A_CNT + 12'h010: prdata_o <= 32'(ecnt_r[4]);
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration and station address; control and high-word upper halves read as zero
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_r <= CTRL_RST;
      sta_lo_r <= 32'h0000_0000;
      sta_hi_r <= 32'h0000_0000;
    end else if (apb_wr) begin
      if (paddr_i == A_CTRL) ctrl_r <= pwdata_i & 32'h0000_0073;
      if (paddr_i == A_STA_LO) sta_lo_r <= pwdata_i;
      if (paddr_i == A_STA_HI) sta_hi_r <= pwdata_i & 32'h0000_FFFF;
    end
  end

  // Suspend and end-of-list flags: hardware set beats software clear
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      susp_r <= 1'b0;
      end_r <= 1'b0;
    end else begin
      if (frame_done_o && fctl_r[SUSP_BIT-16]) susp_r <= 1'b1;
      else if (apb_wr && paddr_i == A_STAT && pwdata_i[SR_SUSP])
        susp_r <= 1'b0;
      if (frame_done_o && fctl_r[LIST_END_BIT-16]) end_r <= 1'b1;
      else if (apb_wr && paddr_i == A_STAT && pwdata_i[SR_END])
        end_r <= 1'b0;
    end
  end

  // Error statistics; a write clears, but a new error still counts
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NCNT; i++) ecnt_r[i] <= '0;
    end else begin
      for (int i = 0; i < NCNT; i++) begin
        if (state_r == S_CALC && stat_r[ST_CRC - i]) begin
          ecnt_r[i] <= ecnt_r[i] + 1'b1;
        end else if (apb_wr && paddr_i == A_CNT + 12'(4 * i)) begin
          ecnt_r[i] <= '0;
        end
      end
    end
  end

  // =====================================================
  // Frame capture
  assign rx_ready_o = (state_r == S_IDLE) & ~susp_r & ~end_r;

  // Descriptor fields latched at setup so fetch logic may move on
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fctl_r <= 16'h0000;
      base_r <= 32'h0000_0000;
      link_r <= 32'h0000_0000;
      size_r <= 14'h0000;
      alen_r <= 3'h0;
    end else if (rx_ready_o && rx_start_i) begin
      fctl_r <= fd_ctrl_i;
      base_r <= fd_base_i;
      link_r <= fd_link_i;
      size_r <= fd_size_i;
      // Address length clamps at six bytes
      alen_r <= (ctrl_r[CT_ALEN+:3] > MAX_ADDR_LEN) ? MAX_ADDR_LEN :
                ctrl_r[CT_ALEN+:3];
    end
  end

  // Header bytes packed in arrival order: dest, source, length
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hcnt_r <= 4'h0;
      for (int i = 0; i < HDR_BYTES; i++) hdr_r[i] <= 8'h00;
    end else if (rx_ready_o && rx_start_i) begin
      hcnt_r <= 4'h0;
      for (int i = 0; i < HDR_BYTES; i++) hdr_r[i] <= 8'h00;
    end else if ((state_r == S_OPEN || state_r == S_RECV) &&
                 rx_byte_valid_i && hcnt_r < hlen) begin
      hdr_r[hcnt_r] <= rx_byte_i;
      hcnt_r <= hcnt_r + 4'h1;
    end
  end

  // End-of-frame report held until the setup write has gone out
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_r <= 1'b0;
      ev_r <= 9'h000;
      cnt_r <= 14'h0000;
      bd_r <= 32'h0000_0000;
    end else if (rx_end_i &&
                 (state_r == S_OPEN || state_r == S_RECV)) begin
      pend_r <= 1'b1;
      ev_r <= {err_len_i, err_crc_i, misalign_i, no_res_i, overrun_i,
               too_short_i, no_close_i, truncated_i, collision_i};
      cnt_r <= rx_count_i;
      bd_r <= layout_sel ? bd_ptr_i : NO_BD;
    end else if (state_r == S_CALC) begin
      pend_r <= 1'b0;
    end
  end

  // Destination compared with station address over its length
  always_comb begin
    logic [47:0] sta;
    sta = {sta_hi_r[15:0], sta_lo_r};
    nomatch = 1'b0;
    for (int i = 0; i < 6; i++) begin
      if (3'(i) < alen_r && hdr_r[i] != sta[8*i+:8]) nomatch = 1'b1;
    end
  end

  // Status word computed once, before any closing write
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_r <= 13'h0000;
      ok_r <= 1'b0;
    end else if (state_r == S_RECV && pend_r) begin
      stat_r <= 13'h0000;
      stat_r[ST_LEN] <= ev_r[8] & ctrl_r[CT_LCHK];
      stat_r[ST_CRC] <= ev_r[7] & ~ev_r[6];
      stat_r[ST_ALN] <= ev_r[7] & ev_r[6];
      stat_r[ST_NRES] <= ev_r[5];
      stat_r[ST_OVR] <= ev_r[4];
      stat_r[ST_SHRT] <= ev_r[3];
      stat_r[ST_NOCL] <= ev_r[2];
      stat_r[ST_TRNC] <= ev_r[1] & ~layout_sel & save_bad;
      stat_r[ST_NOMATCH] <= nomatch;
      stat_r[ST_COLL] <= ev_r[0];
      ok_r <= ~(|{ev_r[8] & ctrl_r[CT_LCHK], ev_r[7:0]});
    end
  end

  // =====================================================
  // Write-back sequencer
  assign wr_go = mem_wvalid_o & mem_wready_i;

  always_comb begin
    state_nxt = state_r;
    widx_nxt = widx_r;
    unique case (state_r)
      S_IDLE: if (rx_ready_o && rx_start_i) state_nxt = S_OPEN;
      S_OPEN: if (wr_go) state_nxt = S_RECV;
      S_RECV: if (pend_r) state_nxt = S_CALC;
      S_CALC: begin
        widx_nxt = 2'h0;
        // Bad frames without save-bad only release the active flag
        state_nxt = (ok_r || save_bad) ? S_HDR : S_FIN;
      end
      S_HDR: if (wr_go) begin
        if (widx_r == hlast) state_nxt = S_W3;
        else widx_nxt = widx_r + 2'h1;
      end
      S_W3: if (wr_go) state_nxt = S_W2;
      S_W2: if (wr_go) state_nxt = S_FIN;
      S_FIN: if (wr_go) state_nxt = S_IDLE;
    endcase
  end

  // Word chosen for the next request
  wire logic keep = ok_r | save_bad;
  always_comb begin
    woff_nxt = W0_OFF;
    wdata_nxt = 32'h0000_0000;
    unique case (state_nxt)
      S_OPEN: wdata_nxt = {fctl_r, 2'b01, 14'h0000};
      S_HDR: begin
        woff_nxt = HDR_OFF + {4'h0, widx_nxt, 2'b00};
        wdata_nxt = {hdr_r[{widx_nxt, 2'd3}], hdr_r[{widx_nxt, 2'd2}],
                     hdr_r[{widx_nxt, 2'd1}], hdr_r[{widx_nxt, 2'd0}]};
      end
      S_W3: begin
        woff_nxt = W3_OFF;
        // Last and used flags set, filled count as in a buffer
        wdata_nxt = {2'b00, size_r, 2'b11, cnt_r};
      end
      S_W2: begin
        woff_nxt = W2_OFF;
        wdata_nxt = bd_r;
      end
      // Done and active flip together with the status
      S_FIN: wdata_nxt = {fctl_r, keep, 1'b0, keep & ok_r,
                          keep ? stat_r : 13'h0000};
      default: wdata_nxt = 32'h0000_0000;
    endcase
  end

  // Registered request; header and status precede word 0 for kept frames
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= S_IDLE;
      widx_r <= 2'h0;
      mem_wvalid_o <= 1'b0;
      mem_addr_o <= 32'h0000_0000;
      mem_data_o <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      widx_r <= widx_nxt;
      if (state_nxt != state_r || widx_nxt != widx_r) begin
        mem_wvalid_o <= state_nxt inside {S_OPEN, S_HDR, S_W3, S_W2,
                                          S_FIN};
        mem_addr_o <= base_r + {24'h00_0000, woff_nxt};
        mem_data_o <= wdata_nxt;
      end
    end
  end

  // Completion pulses and hand-off of the link
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frame_done_o <= 1'b0;
      frame_drop_o <= 1'b0;
      next_fd_o <= 32'h0000_0000;
      bd_follow_o <= 1'b0;
      last_r <= 13'h0000;
    end else begin
      frame_done_o <= (state_r == S_FIN) && wr_go && keep;
      frame_drop_o <= (state_r == S_FIN) && wr_go && !keep;
      if (state_r == S_FIN && wr_go && keep) begin
        next_fd_o <= link_r;
        bd_follow_o <= layout_sel && bd_r != NO_BD;
        last_r <= stat_r;
      end
    end
  end

  assign rx_suspended_o = susp_r;
  assign list_end_o = end_r;

  // =====================================================
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_active;
    mem_wvalid_o && state_r == S_OPEN |->
      mem_data_o[B_BIT] && !mem_data_o[C_BIT];
  endproperty
  a_active: assert property (p_active)
    else $error("setup word lacks active flag");

  property p_close;
    mem_wvalid_o && state_r == S_FIN && keep |->
      mem_data_o[C_BIT] && !mem_data_o[B_BIT];
  endproperty
  a_close: assert property (p_close)
    else $error("closing word flags wrong");

  property p_simp;
    mem_wvalid_o && state_r == S_W2 && !layout_sel |-> mem_data_o == NO_BD;
  endproperty
  a_simp: assert property (p_simp)
    else $error("simplified pointer not all ones");

  property p_flex;
    mem_wvalid_o && state_r == S_W2 && layout_sel |->
      mem_addr_o == base_r + 32'(W2_OFF);
  endproperty
  a_flex: assert property (p_flex)
    else $error("buffer pointer address wrong");

  property p_susp;
    frame_done_o && fctl_r[SUSP_BIT-16] |=> susp_r && !rx_ready_o;
  endproperty
  a_susp: assert property (p_susp)
    else $error("suspend not taken");

  property p_end;
    frame_done_o && fctl_r[LIST_END_BIT-16] |=> end_r [*2];
  endproperty
  a_end: assert property (p_end)
    else $error("end of list not held");

  property p_zero;
    mem_wvalid_o && state_r == S_FIN |-> mem_data_o[4:2] == 3'b000;
  endproperty
  a_zero: assert property (p_zero)
    else $error("reserved status bits set");

  property p_lchk;
    state_r == S_CALC && stat_r[ST_LEN] |-> ctrl_r[CT_LCHK];
  endproperty
  a_lchk: assert property (p_lchk)
    else $error("length error without checking");

  property p_drop;
    frame_drop_o |-> !save_bad && !$past(ok_r);
  endproperty
  a_drop: assert property (p_drop)
    else $error("frame dropped wrongly");

  property p_order;
    $rose(state_r == S_FIN) && keep |-> $past(state_r) == S_W2;
  endproperty
  a_order: assert property (p_order)
    else $error("done written before status");

endmodule

// ---- tb/rfdw_mem_model.sv ----
// Purpose: Shared memory model seen by the descriptor write-back
// Assumes: Descriptors sit in the first 256 bytes
// Notes: Stall mode takes a word only every other cycle
`timescale 1ns/100ps
module rfdw_mem_model (
  input wire logic core_clk_i, // Clock
  input wire logic resetn_i, // Async reset, low
  input wire logic stall_i, // Slow answer mode
  input wire logic mem_wvalid_i, // Write request
  input wire logic [31:0] mem_addr_i, // Write address
  input wire logic [31:0] mem_data_i, // Write data
  output logic mem_wready_o // Write taken
);
  // ==========================================
  // Storage
  logic [31:0] mem [0:63];
  int busy_seen;
  logic phase_r;

  // Host clears every descriptor, active flag included, before use
  initial begin
    busy_seen = 0;
    for (int i = 0; i < 64; i++) begin
      mem[i] = 32'h0000_0000;
    end
  end

  // Slow mode stretches requests so held write data is exercised
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
    end
  end
  assign mem_wready_o = stall_i ? phase_r : 1'b1;

  // Store accepted words, count setups that raise the active flag
  always @(posedge core_clk_i) begin
    if (mem_wvalid_i && mem_wready_o) begin
      mem[mem_addr_i[7:2]] <= mem_data_i;
      // Word 0 only: header words at base+0x10 must not be counted
      if (mem_addr_i[5:0] == 6'h00 && mem_data_i[15:14] == 2'b01) begin
        busy_seen <= busy_seen + 1;
      end
    end
  end
endmodule

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the descriptor write-back
// Assumes: APB slave answers at once, memory model on the far side
// Notes: Each scenario is a task that drives and judges
`timescale 1ns/100ps
module testbench
  import rfdw_pkg::*;
;
  // ==========================================
  // Signals
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, stall;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, fd_base, fd_link, bd_ptr;
  logic serr, rx_ready, rx_start, bv, rx_end, mem_wvalid, mem_wready;
  logic [15:0] fd_ctrl;
  logic [13:0] fd_size, rx_count;
  logic [7:0] bdat;
  logic [8:0] errs;
  logic [31:0] mem_addr, mem_data, next_fd;
  logic done, drop, bd_follow, susp, list_end;
  logic [7:0] hdr [14];
  int err_total, num_checks, cyc;

  rfdw_core #(.CNT_W(16)) rfdw_core_i (
    .core_clk_i(clk), .resetn_i(rstn), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .rx_ready_o(rx_ready), .rx_start_i(rx_start),
    .fd_base_i(fd_base), .fd_ctrl_i(fd_ctrl), .fd_link_i(fd_link),
    .fd_size_i(fd_size), .bd_ptr_i(bd_ptr), .rx_byte_valid_i(bv),
    .rx_byte_i(bdat), .rx_end_i(rx_end), .rx_count_i(rx_count),
    .err_len_i(errs[8]), .err_crc_i(errs[7]), .misalign_i(errs[6]),
    .no_res_i(errs[5]), .overrun_i(errs[4]), .too_short_i(errs[3]),
    .no_close_i(errs[2]), .truncated_i(errs[1]), .collision_i(errs[0]),
    .mem_wvalid_o(mem_wvalid), .mem_addr_o(mem_addr),
    .mem_data_o(mem_data), .mem_wready_i(mem_wready),
    .frame_done_o(done), .frame_drop_o(drop), .next_fd_o(next_fd),
    .bd_follow_o(bd_follow), .rx_suspended_o(susp),
    .list_end_o(list_end)
  );

  rfdw_mem_model rfdw_mem_model_i (
    .core_clk_i(clk), .resetn_i(rstn), .stall_i(stall),
    .mem_wvalid_i(mem_wvalid), .mem_addr_i(mem_addr),
    .mem_data_i(mem_data), .mem_wready_o(mem_wready)
  );

  // ==========================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // A run needs about 200 cycles, so 6000 means a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      give_verdict();
    end
  end

  // ==========================================
  // Shared tasks
  task give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task chk(input logic c, input string m);
    num_checks++;
    if (c !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // One APB transfer, held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n < 50, "no ready");
  endtask

  function automatic logic [7:0] hb(input int k);
    return (k < 14) ? hdr[k] : 8'h00;
  endfunction

  // Start, header bytes, end with error levels, wait for close
  task frame(input logic [31:0] b, input logic [15:0] c, input logic [8:0] e);
    int n;
    @(posedge clk);
    rx_start <= 1'b1;
    fd_base <= b;
    fd_ctrl <= c;
    @(posedge clk);
    rx_start <= 1'b0;
    for (int k = 0; k < 14; k++) begin
      bv <= 1'b1;
      bdat <= hdr[k];
      @(posedge clk);
    end
    bv <= 1'b0;
    rx_end <= 1'b1;
    errs <= e;
    @(posedge clk);
    rx_end <= 1'b0;
    n = 0;
    while (done !== 1'b1 && drop !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(n < 400, "frame never closed");
  endtask

  task chk_desc(input logic [31:0] b, input logic [31:0] w0,
                input logic [31:0] w2);
    int i;
    logic [31:0] x;
    i = int'(b[7:2]);
    chk(rfdw_mem_model_i.mem[i] === w0, "final word0");
    chk(rfdw_mem_model_i.mem[i+2] === w2, "buffer pointer");
    x = {2'b00, fd_size, 2'b11, rx_count};
    chk(rfdw_mem_model_i.mem[i+3] === x, "word3");
    for (int k = 0; k < 4; k++) begin
      x = {hb(4*k+3), hb(4*k+2), hb(4*k+1), hb(4*k)};
      chk(rfdw_mem_model_i.mem[i+4+k] === x, "header");
    end
    chk(next_fd === fd_link, "next descriptor");
  endtask

  // ==========================================
  // Scenarios
  task t_suspend();
    apb(1'b1, A_CTRL, 32'h0000_0062);
    bd_ptr <= 32'h0000_2000;
    frame(32'h0000_0000, 16'h4008, 9'h000);
    chk_desc(32'h0, 32'h4008_A000, 32'h0000_2000);
    chk(bd_follow === 1'b1, "chain to walk");
    // Halt flag is set one edge after the done pulse
    @(negedge clk);
    chk(susp === 1'b1 && rx_ready === 1'b0, "not halted");
    apb(1'b0, A_STAT, 32'h0);
    chk(rd[SR_SUSP] === 1'b1, "halt status");
    apb(1'b1, A_STAT, 32'h0000_0002);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd[SR_SUSP] === 1'b0 && susp === 1'b0, "halt not cleared");
  endtask

  // Saved bad frame in simplified layout, all faults, slow memory
  task t_save_bad();
    apb(1'b1, A_CTRL, 32'h0000_0061);
    hdr[0] = 8'h03;
    stall <= 1'b1;
    frame(32'h0000_0040, 16'h8000, 9'h1FF);
    chk_desc(32'h40, 32'h8000_87E3, NO_BD);
    chk(bd_follow === 1'b0, "followed simplified");
    // End-of-list flag is set one edge after the done pulse
    @(negedge clk);
    chk(list_end === 1'b1 && rx_ready === 1'b0, "list end");
    apb(1'b1, A_STAT, 32'h0000_0004);
    @(negedge clk);
    chk(list_end === 1'b0 && rx_ready === 1'b1, "end not cleared");
    hdr[0] = 8'h02;
    stall <= 1'b0;
  endtask

  task t_len_crc();
    apb(1'b1, A_CTRL, 32'h0000_0063);
    bd_ptr <= NO_BD;
    frame(32'h0000_0080, 16'h0008, 9'h180);
    chk_desc(32'h80, 32'h0008_9800, NO_BD);
    chk(bd_follow === 1'b0, "followed all ones");
  endtask

  task t_drop();
    apb(1'b1, A_CTRL, 32'h0000_0062);
    frame(32'h0000_00C0, 16'h0008, 9'h010);
    chk(drop === 1'b1 && done === 1'b0, "bad frame kept");
    chk(rfdw_mem_model_i.mem[48] === 32'h0008_0000, "drop word0");
  endtask

  // Error counters include the discarded frame; a write clears
  task t_counters();
    logic [31:0] x;
    for (int i = 0; i < 5; i++) begin
      x = (i == 3) ? 32'h0000_0002 : 32'h0000_0001;
      apb(1'b0, A_CNT + 12'(4 * i), 32'h0);
      chk(rd === x, "counter value");
    end
    apb(1'b1, A_CNT + 12'h00C, 32'h0);
    apb(1'b0, A_CNT + 12'h00C, 32'h0);
    chk(rd === 32'h0000_0000, "counter not cleared");
    apb(1'b0, 12'h040, 32'h0);
    chk(serr === 1'b1 && rd === 32'h0000_0000, "unmapped read");
  endtask

  // ==========================================
  // Main sequence
  initial begin
    {rstn, psel, penable, pwrite, rx_start, bv, rx_end, stall} = '0;
    {paddr, pwdata, fd_base, fd_ctrl, bd_ptr, bdat, errs} = '0;
    fd_link = 32'h0000_1230;
    fd_size = 14'h0100;
    rx_count = 14'h0040;
    hdr = '{8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h0A,
            8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h08, 8'h00};
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk(rx_ready === 1'b1 && mem_wvalid === 1'b0, "reset state");
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd === CTRL_RST, "control reset value");
    apb(1'b1, A_STA_LO, 32'h3322_1102);
    apb(1'b1, A_STA_HI, 32'h0000_5544);
    t_suspend();
    t_save_bad();
    t_len_crc();
    t_drop();
    t_counters();
    chk(rfdw_mem_model_i.busy_seen == 4, "active setups");
    give_verdict();
  end
endmodule
